/* core/rve_sq_accum.sv */
`timescale 1ns/100ps
`default_nettype none
module rve_sq_accum #(
    parameter int SAMPLE_W = 8,
    parameter int SUM_W    = 32
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // accumulator carrier
    rve_acc_if.acc    acc
);
    localparam int SQ_W = 2 * SAMPLE_W;

    logic [SUM_W-1:0] sum_q;
    logic [SUM_W-1:0] sum_d;
    logic [SQ_W-1:0]  sq;
    logic signed [SQ_W-1:0] err_x;
    logic [SUM_W:0]   wide;

    always_comb begin
        err_x = {{(SQ_W-SAMPLE_W-1){acc.err[SAMPLE_W]}}, acc.err};
        sq    = SQ_W'(err_x * err_x);
        wide  = {1'b0, sum_q} + (SUM_W+1)'(sq);
        sum_d = sum_q;
        if (acc.clear) begin
            sum_d = '0;
        end else if (acc.valid) begin
            // saturate rather than wrap: a wrapped sum would look like a clean link
            sum_d = wide[SUM_W] ? '1 : wide[SUM_W-1:0]; // RQ14
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sum_q <= '0;
        end else begin
            sum_q <= sum_d;
        end
    end

    assign acc.sum = sum_q;
endmodule : rve_sq_accum
`default_nettype wire

/* core/rve_variance.sv */
`timescale 1ns/100ps
`default_nettype none
// Contract
// RQ1: ready flag sets when new sum loads
// RQ2: ready clears after two consecutive data reads
// RQ3: freeze holds data; self-clears after two reads
// RQ4: period field selects 2/4/6/8 units
// RQ5: writing new period restarts the computation
// RQ6: result loads only after full period
// RQ7: one unit is 2^17 clock cycles
// RQ8: computes only while enable set; reset off
// RQ9: 32-bit sum through one 16-bit register
// RQ10: software trusts data only when ready
// RQ11: software sets freeze before reading data
// RQ12: first read low half, second high half
// RQ13: control bits 14..4 read zero
// RQ14: saturating sum of squared slicer errors
module rve_variance #(
    // cycles per window unit; a small value only shortens simulation
    parameter int UNIT_CYCLES = rve_pkg::UNIT_CYCLES,
    parameter int SAMPLE_W    = rve_pkg::SAMPLE_W
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    // receive samples, same clock domain
    input  wire logic                smp_valid_i,
    input  wire logic [SAMPLE_W-1:0] smp_eq_i,
    input  wire logic [SAMPLE_W-1:0] smp_dec_i,
    // management register port
    input  wire logic [4:0]          reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [15:0]         reg_wdata_i,
    output logic      [15:0]         reg_rdata_o,
    // status
    output logic                     var_ready_o
);
    localparam int CYC_W = $clog2(UNIT_CYCLES + 1);

    rve_acc_if #(.SAMPLE_W(SAMPLE_W), .SUM_W(rve_pkg::SUM_W)) acc_if ();

    rve_sq_accum #(
        .SAMPLE_W (SAMPLE_W),
        .SUM_W    (rve_pkg::SUM_W)
    ) u_accum (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .acc      (acc_if.acc)
    );

    // control and data state
    logic                      enable_q,  enable_d;
    logic                      freeze_q,  freeze_d;
    logic [1:0]                timer_q,   timer_d;
    logic                      ready_q,   ready_d;
    logic [rve_pkg::SUM_W-1:0] data_q,    data_d;
    rve_pkg::rve_half_e        half_q,    half_d;
    logic [CYC_W-1:0]          cyc_q,     cyc_d;
    logic [3:0]                units_q,   units_d;
    logic [15:0]               rdata_q,   rdata_d;

    // decode and strobes
    logic        ctrl_wr;
    logic        data_rd;
    logic        pair_done;
    logic        restart;
    logic        unit_end;
    logic        period_end;
    logic [3:0]  period_units;
    logic [15:0] ctrl_view;

    always_comb begin
        ctrl_wr  = reg_wr_i && (reg_addr_i == rve_pkg::CTRL_ADDR);
        data_rd  = reg_rd_i && (reg_addr_i == rve_pkg::DATA_ADDR);
        // 2, 4, 6 or 8 units for codes 0..3
        period_units = {1'b0, timer_q, 1'b0} + 4'h2; // RQ4
        // restart only when the period code really changes
        restart  = ctrl_wr &&
                   (reg_wdata_i[rve_pkg::TIMER_LSB +: 2] != timer_q); // RQ5
        unit_end = (cyc_q == CYC_W'(UNIT_CYCLES - 1)); // RQ7
        period_end = enable_q && unit_end &&
                     (units_q == period_units - 4'h1); // RQ6
        // the high-half read closes a pair and releases ready and freeze
        pair_done  = data_rd && (half_q == rve_pkg::RVE_HALF_HI);
    end

    // control register image; unused bits stay zero whatever was written
    always_comb begin
        ctrl_view = '0; // RQ13
        ctrl_view[rve_pkg::RDY_BIT]    = ready_q;
        ctrl_view[rve_pkg::FREEZE_BIT] = freeze_q;
        ctrl_view[rve_pkg::TIMER_LSB +: 2] = timer_q;
        ctrl_view[rve_pkg::ENABLE_BIT] = enable_q;
    end

    // accumulator steering
    // a sample on the closing edge is dropped along with the clear
    always_comb begin
        acc_if.clear = !enable_q || restart || period_end; // RQ8
        acc_if.valid = enable_q && smp_valid_i; // RQ8
        // sign-extend both so that the difference cannot wrap
        acc_if.err   = {smp_eq_i[SAMPLE_W-1], smp_eq_i} -
                       {smp_dec_i[SAMPLE_W-1], smp_dec_i}; // RQ14
    end

    // window timer
    // it runs from the edge that enables or restarts it
    always_comb begin
        cyc_d   = cyc_q;
        units_d = units_q;
        if (!enable_q || restart) begin
            cyc_d   = '0; // RQ5
            units_d = '0;
        end else if (unit_end) begin
            cyc_d   = '0;
            units_d = period_end ? 4'h0 : units_q + 4'h1;
        end else begin
            cyc_d   = cyc_q + CYC_W'(1);
        end
    end

    // window counters
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_q   <= '0;
            units_q <= 4'h0;
        end else begin
            cyc_q   <= cyc_d;
            units_q <= units_d;
        end
    end

    // control fields; a write that sets freeze beats the closing read
    always_comb begin
        enable_d = enable_q;
        freeze_d = freeze_q;
        timer_d  = timer_q;
        if (pair_done) begin
            freeze_d = 1'b0; // RQ3
        end
        if (ctrl_wr) begin
            enable_d = reg_wdata_i[rve_pkg::ENABLE_BIT];
            freeze_d = reg_wdata_i[rve_pkg::FREEZE_BIT];
            timer_d  = reg_wdata_i[rve_pkg::TIMER_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable_q <= rve_pkg::ENABLE_RST; // RQ8
            freeze_q <= rve_pkg::FREEZE_RST;
            timer_q  <= rve_pkg::TIMER_RST;
        end else begin
            enable_q <= enable_d;
            freeze_q <= freeze_d;
            timer_q  <= timer_d;
        end
    end

    // result: a half-read pair also blocks the load so the halves match
    // the load is skipped, not delayed, so that window's result is lost
    always_comb begin
        ready_d = ready_q;
        data_d  = data_q;
        if (pair_done) begin
            ready_d = 1'b0; // RQ2
        end
        // placed after the clear so that a load in the same cycle wins
        if (period_end && !freeze_q &&
            (half_q == rve_pkg::RVE_HALF_LO)) begin // RQ3
            data_d  = acc_if.sum; // RQ6
            ready_d = 1'b1; // RQ1
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_q <= rve_pkg::READY_RST;
            data_q  <= rve_pkg::DATA_RST;
        end else begin
            ready_q <= ready_d;
            data_q  <= data_d;
        end
    end

    // read port: unmapped reads return zero and keep the pairing
    always_comb begin
        half_d  = half_q;
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            if (reg_addr_i == rve_pkg::CTRL_ADDR) begin
                rdata_d = ctrl_view;
                half_d  = rve_pkg::RVE_HALF_LO;
            end else if (data_rd) begin
                if (half_q == rve_pkg::RVE_HALF_LO) begin
                    rdata_d = data_q[15:0]; // RQ12
                    half_d  = rve_pkg::RVE_HALF_HI;
                end else begin
                    rdata_d = data_q[31:16]; // RQ9
                    half_d  = rve_pkg::RVE_HALF_LO;
                end
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            half_q  <= rve_pkg::RVE_HALF_LO;
            rdata_q <= 16'h0000;
        end else begin
            half_q  <= half_d;
            rdata_q <= rdata_d;
        end
    end

    // both outputs come straight from their registers
    assign reg_rdata_o = rdata_q;
    assign var_ready_o = ready_q;
endmodule : rve_variance
`default_nettype wire

/* shared/rve_acc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface rve_acc_if #(
    parameter int SAMPLE_W = 8,
    parameter int SUM_W    = 32
);
    logic                       clear;
    logic                       valid;
    // one bit wider than a sample: eq minus dec spans twice the range
    logic signed [SAMPLE_W:0]   err;
    logic        [SUM_W-1:0]    sum;
    modport ctrl (output clear, output valid, output err, input sum);
    modport acc  (input clear, input valid, input err, output sum);
endinterface : rve_acc_if
`default_nettype wire

/* shared/rve_pkg.sv */
`default_nettype none
package rve_pkg;
    // management register offsets
    localparam logic [4:0]  CTRL_ADDR    = 5'h1a;
    localparam logic [4:0]  DATA_ADDR    = 5'h1b;
    // control register fields
    localparam int          RDY_BIT      = 15;
    localparam int          FREEZE_BIT   = 3;
    localparam int          TIMER_LSB    = 1;
    localparam int          ENABLE_BIT   = 0;
    localparam logic [1:0]  TIMER_RST    = 2'h0;
    localparam logic        ENABLE_RST   = 1'b0;
    localparam logic        FREEZE_RST   = 1'b0;
    localparam logic        READY_RST    = 1'b0;
    localparam logic [31:0] DATA_RST     = 32'h0000_0000;
    // one time unit of the window
    localparam int          CLK_NS       = 8;
    localparam int          UNIT_PS      = 1048576000;
    localparam int          UNIT_CYCLES  = UNIT_PS / (CLK_NS * 1000);
    // sample and sum widths
    localparam int          SAMPLE_W     = 8;
    localparam int          SUM_W        = 32;
    typedef enum logic [0:0] {
        RVE_HALF_LO = 1'b0,
        RVE_HALF_HI = 1'b1
    } rve_half_e;
endpackage : rve_pkg
`default_nettype wire

/* testbench/receive_variance_estimator_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
    num_errors++; $display("mismatch %0t %s", $time, m); end end
module receive_variance_estimator_tb;
    localparam int         U  = 8;
    localparam logic [4:0] CA = rve_pkg::CTRL_ADDR;
    localparam logic [4:0] DA = rve_pkg::DATA_ADDR;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        smp_valid_i = 1'b0;
    logic [7:0]  smp_eq_i = 8'h00;
    logic [7:0]  smp_dec_i = 8'h00;
    logic [4:0]  reg_addr_i = 5'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic        var_ready_o;
    int          num_errors = 0;
    int          checked = 0;
    always #5 clk_i = ~clk_i;
    rve_variance #(.UNIT_CYCLES(U), .SAMPLE_W(8)) i_dut (.clk_i, .arst_n_i,
        .smp_valid_i, .smp_eq_i, .smp_dec_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .var_ready_o);
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, exp, "read data")
    endtask
    task automatic feed(input logic [7:0] e, input logic [7:0] d, input int n);
        repeat (n) begin
            @(posedge clk_i);
            smp_valid_i <= 1'b1;
            smp_eq_i <= e;
            smp_dec_i <= d;
        end
        @(posedge clk_i);
        smp_valid_i <= 1'b0;
    endtask
    // elapsed cycles from the window start to the ready flag
    task automatic wait_rdy(input time t0, input int p);
        int n;
        n = 0;
        while (var_ready_o !== 1'b1) begin
            if (++n > 300) begin
                num_errors++;
                report_and_stop();
            end
            @(posedge clk_i);
            #1;
        end
        n = int'(($time - t0) / 10);
        `CHK(n >= p && n <= p + 2, 1'b1, "window length")
    endtask
    task automatic t_reset();
        rd(CA, 16'h0000);
        rd(DA, 16'h0000);
        rd(5'h1c, 16'h0000);
        $display("reset values done");
    endtask
    task automatic t_ctrl_bits();
        wr(CA, 16'hfff6);
        rd(CA, 16'h0006);
        wr(CA, 16'h0000);
        $display("control bits done");
    endtask
    task automatic t_window(input logic [1:0] c);
        int p;
        p = 2 * (c + 1) * U;
        feed(8'h40, 8'h00, 2);
        wr(CA, {13'h0000, c, 1'b1});
        feed(8'h80, 8'h7f, 4);
        wait_rdy($time - 60, p);
        rd(CA, {1'b1, 11'h000, 1'b0, c, 1'b1});
        wr(CA, {12'h000, 1'b1, c, 1'b1});
        rd(CA, {1'b1, 11'h000, 1'b1, c, 1'b1});
        // a later window ends during this wait and must not replace the data
        repeat (p) @(posedge clk_i);
        rd(DA, 16'hf804);
        rd(DA, 16'h0003);
        `CHK(var_ready_o, 1'b0, "ready flag")
        rd(CA, {13'h0000, c, 1'b1});
        wr(CA, 16'h0000);
        $display("window code %0d done", c);
    endtask
    task automatic t_restart();
        wr(CA, 16'h0003);
        feed(8'h80, 8'h7f, 4);
        repeat (10) @(posedge clk_i);
        wr(CA, 16'h0001);
        feed(8'h02, 8'h00, 1);
        wait_rdy($time - 30, 2 * U);
        wr(CA, 16'h0009);
        rd(DA, 16'h0004);
        rd(DA, 16'h0000);
        $display("restart done");
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_ctrl_bits();
        for (int c = 0; c < 4; c++)
            t_window(2'(c));
        t_restart();
        report_and_stop();
    end
endmodule // receive_variance_estimator_tb
bind rve_variance rve_variance_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) i_mon (
    .clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .var_ready_o);
`default_nettype wire

/* testbench/rve_variance_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module rve_variance_monitor #(
    parameter int UNIT_CYCLES = rve_pkg::UNIT_CYCLES
) (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic [4:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        var_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic        ctl_rd;
    logic        dat_rd;
    logic        off_wr;
    logic [31:0] idle_q;
    assign ctl_rd = reg_rd_i && reg_addr_i == rve_pkg::CTRL_ADDR;
    assign dat_rd = reg_rd_i && reg_addr_i == rve_pkg::DATA_ADDR;
    assign off_wr = reg_wr_i && reg_addr_i == rve_pkg::CTRL_ADDR
                    && !reg_wdata_i[rve_pkg::ENABLE_BIT];
    // any window starts after the last switch-off, so a load needs a full one
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            idle_q <= 32'h0000_0000;
        else if (off_wr)
            idle_q <= 32'h0000_0000;
        else if (idle_q != 32'hffff_ffff)
            idle_q <= idle_q + 32'h0000_0001;
    end
    a_ctrl_rsv_zero: assert property (ctl_rd |=> reg_rdata_o[14:4] == 11'h000)
        else $error("control reserved bits not zero");
    a_ctrl_rdy_copy: assert property (ctl_rd |=> reg_rdata_o[15] == $past(var_ready_o))
        else $error("ready bit differs from flag");
    a_unmapped_zero: assert property (reg_rd_i && !ctl_rd && !dat_rd |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_ready_holds: assert property (var_ready_o && !dat_rd |=> var_ready_o)
        else $error("ready dropped without data read");
    a_ready_fall_rd: assert property ($fell(var_ready_o) |-> $past(dat_rd))
        else $error("ready fell without data read");
    a_no_early_load: assert property ($rose(var_ready_o) |-> idle_q >= 2 * UNIT_CYCLES)
        else $error("result loaded before window end");
    a_reset_quiet: assert property (!$past(arst_n_i) |-> reg_rdata_o == 16'h0000 && !var_ready_o)
        else $error("outputs not clear after reset");
    c_ready_set: cover property ($rose(var_ready_o));
    c_ready_clr: cover property ($fell(var_ready_o));
    c_two_reads: cover property (dat_rd ##2 dat_rd);
endmodule // rve_variance_monitor
`default_nettype wire
